// ---- aotc_top.sv ----
// Purpose: amplifier offset trim registers, amp configuration and conversion busy control
// Assumes: Avalon-MM slave, one wait cycle per access, inputs synchronous to core_clk
// Notes:   the converter itself is outside; this block holds its busy flag
// Notes on behaviour
// - any reset loads both trims with 40h
// - negative reference enable selects reference, mutes mux
// - positive reference enable selects reference, mutes mux
// - bit 6 is trim sign
// - bits 5..0 are trim magnitude
// - calibration bit forces amp on, open loop
// - busy set starts conversion, completion clears
module aotc_top
    import aotc_pkg::*;
#(
    parameter int CONV_CYCLES = AOTC_CONV_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_result,
    output logic             neg_pair_reference,
    output logic             pos_pair_reference,
    output logic             mux_disable,
    output logic             amp_enable,
    output logic             amp_open_loop,
    output logic      [2:0]  amplification_factor_field,
    output logic      [6:0]  neg_correction_value,
    output logic      [6:0]  pos_correction_value,
    output logic             conv_start,
    output logic             conversion_busy_flag
);
    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait cycle per access keeps read data registered
    logic        ack_r;
    logic [31:0] rdata_r;
    logic        req;
    logic        take;
    assign req             = avs_read | avs_write;
    assign take            = req & ~ack_r;
    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata    = rdata_r;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic wr_low;
    logic sel_neg;
    logic sel_pos;
    logic sel_amp;
    logic sel_conv;
    logic wr_neg;
    logic wr_pos;
    logic wr_amp;
    logic wr_conv;
    assign wr_low   = take & avs_write & avs_byteenable[0];
    assign sel_neg  = avs_address == AOTC_NEG_TRIM_OFS;
    assign sel_pos  = avs_address == AOTC_POS_TRIM_OFS;
    assign sel_amp  = avs_address == AOTC_AMP_CTRL_OFS;
    assign sel_conv = avs_address == AOTC_CONV_CTRL_OFS;
    assign wr_neg   = wr_low & sel_neg;
    assign wr_pos   = wr_low & sel_pos;
    assign wr_amp   = wr_low & sel_amp;
    assign wr_conv  = wr_low & sel_conv;

    // ------------------------------------------------------------
    // trim registers
    // ------------------------------------------------------------
    logic [7:0] neg_val;
    logic [7:0] pos_val;
    logic       neg_ref;
    logic       pos_ref;
    logic       neg_sign;
    logic       pos_sign;
    logic [5:0] neg_mag;
    logic [5:0] pos_mag;

    aotc_trim_reg u_neg (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .wr_en      (wr_neg),
        .wr_data    (avs_writedata[7:0]),
        .value      (neg_val),
        .ref_enable (neg_ref),
        .sign_pos   (neg_sign),
        .magnitude  (neg_mag)
    );

    aotc_trim_reg u_pos (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .wr_en      (wr_pos),
        .wr_data    (avs_writedata[7:0]),
        .value      (pos_val),
        .ref_enable (pos_ref),
        .sign_pos   (pos_sign),
        .magnitude  (pos_mag)
    );

    // ------------------------------------------------------------
    // amplifier control
    // ------------------------------------------------------------
    logic [7:0] amplifier_control_reg_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            amplifier_control_reg_r <= AOTC_AMP_CTRL_RST;
        end else if (wr_amp) begin
            // reserved bits forced to zero
            amplifier_control_reg_r <= avs_writedata[7:0] & AOTC_AMP_CTRL_MASK;
        end
    end

    logic       cal_cfg;
    logic [2:0] gain_sel;
    assign cal_cfg  = amplifier_control_reg_r[AOTC_CAL_CFG_BIT];
    assign gain_sel = amplifier_control_reg_r[AOTC_GAIN_MSB:0];

    // ------------------------------------------------------------
    // analog control outputs, registered
    // ------------------------------------------------------------
    logic        neg_ref_r;
    logic        pos_ref_r;
    logic        mux_dis_r;
    logic        amp_en_r;
    logic        open_loop_r;
    logic [2:0]  gain_r;
    logic [6:0]  neg_corr_r;
    logic [6:0]  pos_corr_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            neg_ref_r   <= 1'b0;
            pos_ref_r   <= 1'b0;
            mux_dis_r   <= 1'b0;
            amp_en_r    <= 1'b0;
            open_loop_r <= 1'b0;
            gain_r      <= 3'h0;
            neg_corr_r  <= AOTC_TRIM_RST[6:0];
            pos_corr_r  <= AOTC_TRIM_RST[6:0];
        end else begin
            neg_ref_r   <= neg_ref;
            pos_ref_r   <= pos_ref;
            mux_dis_r   <= neg_ref | pos_ref;
            amp_en_r    <= cal_cfg | (gain_sel != 3'h0);
            open_loop_r <= cal_cfg;
            gain_r      <= gain_sel;
            neg_corr_r  <= {neg_sign, neg_mag};
            pos_corr_r  <= {pos_sign, pos_mag};
        end
    end
    assign neg_pair_reference         = neg_ref_r;
    assign pos_pair_reference         = pos_ref_r;
    assign mux_disable                = mux_dis_r;
    assign amp_enable                 = amp_en_r;
    assign amp_open_loop              = open_loop_r;
    assign amplification_factor_field = gain_r;
    assign neg_correction_value       = neg_corr_r;
    assign pos_correction_value       = pos_corr_r;

    ref_mux_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        neg_ref |=> mux_disable && neg_pair_reference)
        else $error("negative reference did not mute mux");
    pos_mux_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pos_ref |=> mux_disable && pos_pair_reference)
        else $error("positive reference did not mute mux");
    open_loop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        cal_cfg |=> amp_enable && amp_open_loop)
        else $error("calibration config did not force open loop");
    corr_track_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_neg |=> ##1 neg_correction_value == $past(avs_writedata[6:0], 2))
        else $error("negative correction not applied");

    // ------------------------------------------------------------
    // conversion busy control
    // ------------------------------------------------------------
    // the flag doubles as the converter run enable
    localparam int CW = $clog2(CONV_CYCLES + 1);
    logic          busy_r;
    logic [CW-1:0] conv_cnt_r;
    logic [9:0]    result_r;
    logic          start_r;
    logic          busy_set;
    logic          count_done;
    logic          finish;
    assign busy_set   = wr_conv & avs_writedata[AOTC_BUSY_BIT] & ~busy_r;
    assign count_done = busy_r & (conv_cnt_r == CW'(1));
    assign finish     = busy_r & (conv_done | count_done);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r     <= 1'b0;
            conv_cnt_r <= '0;
            start_r    <= 1'b0;
            result_r   <= 10'h000;
        end else begin
            start_r <= busy_set;
            if (busy_set) begin
                busy_r     <= 1'b1;
                conv_cnt_r <= CW'(CONV_CYCLES);
            end else if (wr_conv & ~avs_writedata[AOTC_BUSY_BIT]) begin
                busy_r <= 1'b0;
            end else if (finish) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                conv_cnt_r <= conv_cnt_r - CW'(1);
            end
            if (finish) begin
                result_r <= conv_result;
            end
        end
    end
    assign conv_start           = start_r;
    assign conversion_busy_flag = busy_r;

    busy_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (finish && !wr_conv) |=> !conversion_busy_flag)
        else $error("busy not cleared on completion");
    start_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        busy_set |=> conv_start && conversion_busy_flag)
        else $error("conversion not started");

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    logic [7:0] conv_byte;
    logic [7:0] res_lo;
    assign conv_byte = {7'h00, busy_r};
    assign res_lo    = {result_r[1:0], 6'h00};
    assign rd_byte   = sel_neg  ? neg_val :
                       sel_pos  ? pos_val :
                       sel_amp  ? amplifier_control_reg_r :
                       sel_conv ? conv_byte : 8'h00;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (take & avs_read) begin
            rdata_r <= sel_conv ? {8'h00, result_r[9:2], res_lo, conv_byte} : {24'h00_0000, rd_byte};
        end
    end

    bus_answer_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer took more than one wait cycle");
endmodule

// ---- aotc_pkg.sv ----
// Purpose: shared constants for the amplifier offset trim block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   register offsets are word aligned
package aotc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] AOTC_NEG_TRIM_OFS  = 4'h0;
    localparam logic [3:0] AOTC_POS_TRIM_OFS  = 4'h4;
    localparam logic [3:0] AOTC_AMP_CTRL_OFS  = 4'h8;
    localparam logic [3:0] AOTC_CONV_CTRL_OFS = 4'hc;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int AOTC_REF_EN_BIT  = 7;
    localparam int AOTC_SIGN_BIT    = 6;
    localparam int AOTC_MAG_MSB     = 5;
    localparam int AOTC_CAL_CFG_BIT = 5;
    localparam int AOTC_BUSY_BIT    = 0;
    localparam int AOTC_GAIN_MSB    = 2;
    localparam logic [7:0] AOTC_TRIM_RST     = 8'h40;
    localparam logic [7:0] AOTC_AMP_CTRL_RST = 8'h00;
    // amp control: bit7 aux amp, bit6 temp sensor, bit5 cal cfg, bits4:3 reserved, 2:0 gain
    localparam logic [7:0] AOTC_AMP_CTRL_MASK = 8'he7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int AOTC_CLK_HZ        = 50000000;
    localparam int AOTC_CONV_TIME_NS  = 12000;
    localparam int AOTC_CONV_CYCLES   = (AOTC_CONV_TIME_NS * (AOTC_CLK_HZ / 1000000) + 999) / 1000;
endpackage

// ---- aotc_trim_reg.sv ----
// Purpose: one offset trim register with decoded analog controls
// Assumes: write strobe is a one-cycle pulse
// Notes:   contents change only by write or reset
module aotc_trim_reg
    import aotc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] value,
    output logic            ref_enable,
    output logic            sign_pos,
    output logic      [5:0] magnitude
);
    logic [7:0] trim_r;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trim_r <= AOTC_TRIM_RST;
        end else if (wr_en) begin
            trim_r <= wr_data;
        end
    end

    assign value      = trim_r;
    assign ref_enable = trim_r[AOTC_REF_EN_BIT];
    assign sign_pos   = trim_r[AOTC_SIGN_BIT];
    assign magnitude  = trim_r[AOTC_MAG_MSB:0];

    hold_value_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !$past(wr_en) |-> trim_r == $past(trim_r))
        else $error("trim register changed without a write");
    write_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_en |=> trim_r == $past(wr_data))
        else $error("trim register missed a write");
endmodule

// ---- aotc_top_tb.sv ----
// Purpose: self-checking bench for the amplifier offset trim block
// Assumes: one wait cycle per bus request, CONV_CYCLES shortened to 40
// Notes:   the bench drives every input itself, no partner model
module aotc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aotc_pkg::*;
    localparam int CONV_N = 40;
    // open-loop settle scaled down from 1.05 ms so the run stays short
    localparam int SETTLE_N = 20;
    // gain 5 settle, 6 us at 50 MHz
    localparam int GAIN5_SETTLE_N = 300;
    // offset the bench amplifier needs trimmed out: positive, magnitude 2bh
    localparam logic [5:0] CAL_T = 6'h2b;
    logic        core_clk;
    logic        sys_rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        conv_done;
    logic [9:0]  conv_result;
    logic        neg_pair_reference;
    logic        pos_pair_reference;
    logic        mux_disable;
    logic        amp_enable;
    logic        amp_open_loop;
    logic [2:0]  amplification_factor_field;
    logic [6:0]  neg_correction_value;
    logic [6:0]  pos_correction_value;
    logic        conv_start;
    logic        conversion_busy_flag;
    int          mismatches;
    int          compares;
    int          starts;
    logic [31:0] q;
    aotc_top #(.CONV_CYCLES(CONV_N)) aotc_top_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .conv_done(conv_done), .conv_result(conv_result),
        .neg_pair_reference(neg_pair_reference), .pos_pair_reference(pos_pair_reference),
        .mux_disable(mux_disable), .amp_enable(amp_enable), .amp_open_loop(amp_open_loop),
        .amplification_factor_field(amplification_factor_field),
        .neg_correction_value(neg_correction_value), .pos_correction_value(pos_correction_value),
        .conv_start(conv_start), .conversion_busy_flag(conversion_busy_flag));
    // ------------------------------------------------------------
    // clock, reset, watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
    always @(posedge core_clk) begin
        if (conv_start === 1'b1) starts++;
    end
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic fail(input string m);
        mismatches++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) fail($sformatf("outputs %h expected %h", got, exp));
    endtask
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d}, 4'hf);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h00000000, 4'hf);
        chk_rd(q, {24'h000000, e});
    endtask
    // analog side registers one cycle after the register
    task automatic pins(input logic [7:0] e, input logic [6:0] n, input logic [6:0] p);
        @(negedge core_clk);
        chk_pin({neg_pair_reference, pos_pair_reference, mux_disable, amp_enable, amp_open_loop,
                 amplification_factor_field}, e);
        chk_pin({n, 1'b0}, {neg_correction_value, 1'b0});
        chk_pin({p, 1'b0}, {pos_correction_value, 1'b0});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(AOTC_NEG_TRIM_OFS, AOTC_TRIM_RST);
        rd(AOTC_POS_TRIM_OFS, AOTC_TRIM_RST);
        rd(AOTC_AMP_CTRL_OFS, AOTC_AMP_CTRL_RST);
        pins(8'h00, 7'h40, 7'h40);
        $display("test reset done");
    endtask
    task automatic t_trim();
        wr(AOTC_NEG_TRIM_OFS, 8'hc0);
        rd(AOTC_NEG_TRIM_OFS, 8'hc0);
        pins(8'ha0, 7'h40, 7'h40);
        wr(AOTC_NEG_TRIM_OFS, 8'h3f);
        pins(8'h00, 7'h3f, 7'h40);
        wr(AOTC_POS_TRIM_OFS, 8'h80);
        pins(8'h60, 7'h3f, 7'h00);
        wr(AOTC_POS_TRIM_OFS, 8'h7f);
        pins(8'h00, 7'h3f, 7'h7f);
        // lane 0 off: write must not land
        bus(1'b1, AOTC_NEG_TRIM_OFS, 32'h000000ff, 4'he);
        rd(AOTC_NEG_TRIM_OFS, 8'h3f);
        rd(4'h2, 8'h00);
        $display("test trim done");
    endtask
    task automatic t_amp();
        wr(AOTC_AMP_CTRL_OFS, 8'h20);
        pins(8'h18, 7'h3f, 7'h7f);
        wr(AOTC_AMP_CTRL_OFS, 8'hff);
        rd(AOTC_AMP_CTRL_OFS, AOTC_AMP_CTRL_MASK);
        pins(8'h1f, 7'h3f, 7'h7f);
        wr(AOTC_AMP_CTRL_OFS, 8'h03);
        repeat (GAIN5_SETTLE_N) @(posedge core_clk);
        pins(8'h13, 7'h3f, 7'h7f);
        wr(AOTC_AMP_CTRL_OFS, 8'h00);
        pins(8'h00, 7'h3f, 7'h7f);
        $display("test amp done");
    endtask
    task automatic t_conv();
        int n;
        n = 0;
        conv_result <= 10'h2d5;
        wr(AOTC_CONV_CTRL_OFS, 8'h01);
        chk_pin({7'h00, conversion_busy_flag}, 8'h01);
        bus(1'b0, AOTC_CONV_CTRL_OFS, 32'h00000000, 4'hf);
        chk_rd({31'h0, q[AOTC_BUSY_BIT]}, 32'h1);
        do begin
            bus(1'b0, AOTC_CONV_CTRL_OFS, 32'h00000000, 4'hf);
            n++;
        end while (q[AOTC_BUSY_BIT] !== 1'b0 && n < 30);
        chk_rd(q, {8'h00, 8'hb5, 2'b01, 14'h0000});
        // converter finishes early
        conv_result <= 10'h12a;
        wr(AOTC_CONV_CTRL_OFS, 8'h01);
        @(posedge core_clk);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        bus(1'b0, AOTC_CONV_CTRL_OFS, 32'h00000000, 4'hf);
        chk_rd(q, {8'h00, 8'h4a, 2'b10, 14'h0000});
        // abort by writing zero
        wr(AOTC_CONV_CTRL_OFS, 8'h01);
        wr(AOTC_CONV_CTRL_OFS, 8'h00);
        bus(1'b0, AOTC_CONV_CTRL_OFS, 32'h00000000, 4'hf);
        chk_rd({31'h0, q[AOTC_BUSY_BIT]}, 32'h0);
        chk_rd(starts, 32'h3);
        rd(AOTC_NEG_TRIM_OFS, 8'h3f);
        rd(AOTC_POS_TRIM_OFS, 8'h7f);
        $display("test conversion done");
    endtask
    // bench amplifier: top result bits tell which side of the offset the trim sits
    function automatic logic [9:0] amp_out(input logic [5:0] m);
        return (m < CAL_T) ? 10'h3ff : (m > CAL_T) ? 10'h000 : 10'h200;
    endfunction
    // settle, start, let the converter finish early, save the result in q
    task automatic convert(input logic [5:0] m);
        repeat (SETTLE_N) @(posedge core_clk);
        conv_result <= amp_out(m);
        wr(AOTC_CONV_CTRL_OFS, 8'h01);
        @(posedge core_clk);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        bus(1'b0, AOTC_CONV_CTRL_OFS, 32'h00000000, 4'hf);
        chk_pin({7'h00, conversion_busy_flag}, 8'h00);
    endtask
    // software trim routine on the negative pair, positive pair only touched
    task automatic t_cal();
        logic [7:0] t;
        logic [2:0] top;
        int         b;
        t = 8'hc0;
        wr(AOTC_AMP_CTRL_OFS, 8'h20);
        wr(AOTC_NEG_TRIM_OFS, t);
        convert(t[5:0]);
        top = q[23:21];
        if (top == 3'b000) t[AOTC_SIGN_BIT] = 1'b0;
        b = (top == 3'b111 || top == 3'b000) ? AOTC_MAG_MSB : -1;
        while (b >= 0) begin
            t[b] = 1'b1;
            wr(AOTC_NEG_TRIM_OFS, t);
            convert(t[5:0]);
            top = q[23:21];
            if (top != 3'b111 && top != 3'b000) begin
                b = -1;
            end else begin
                if ((top == 3'b000) == t[AOTC_SIGN_BIT]) t[b] = 1'b0;
                b--;
            end
        end
        wr(AOTC_NEG_TRIM_OFS, {1'b0, t[6:0]});
        rd(AOTC_NEG_TRIM_OFS, {2'b01, CAL_T});
        wr(AOTC_POS_TRIM_OFS, 8'hc0);
        wr(AOTC_POS_TRIM_OFS, 8'h40);
        wr(AOTC_AMP_CTRL_OFS, 8'h00);
        pins(8'h00, {1'b1, CAL_T}, 7'h40);
        $display("test calibration done");
    endtask
    task automatic t_rerst();
        wr(AOTC_NEG_TRIM_OFS, 8'hd5);
        wr(AOTC_AMP_CTRL_OFS, 8'h20);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(AOTC_NEG_TRIM_OFS, AOTC_TRIM_RST);
        rd(AOTC_POS_TRIM_OFS, AOTC_TRIM_RST);
        pins(8'h00, 7'h40, 7'h40);
        $display("test second reset done");
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mismatches = 0;
        compares = 0;
        starts = 0;
        sys_rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        conv_done = 1'b0;
        conv_result = 10'h000;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_trim();
        t_amp();
        t_conv();
        t_cal();
        t_rerst();
        stop_test();
    end
endmodule
